/* File: cgr_pkg.sv */
`default_nettype none

package cgr_pkg;

	// Staged and live system configuration width and its value out of hardware reset.
	localparam int          CFG_W         = 16;
	localparam logic [15:0] CFG_RST       = 16'h0000;

	// Soft reset trigger pattern in the low bits of the soft reset register.
	localparam int          SWR_W         = 16;
	localparam logic [2:0]  SWR_PATTERN   = 3'h7;
	localparam logic [7:0]  SWR_LEN       = 8'h04;

	// Field positions inside the PLL control register.
	localparam int          PLL_W         = 16;
	localparam int          MULT_SELECT_LSB      = 0;
	localparam int          MULT_SELECT_W        = 7;
	localparam int          HALVE_IN_BIT  = 7;
	localparam int          BYP_HALVE_BIT = 8;
	localparam int          PER_RATIO_BIT = 9;
	localparam int          CLKOE_BIT     = 10;
	localparam int          PLL_OFF_BIT   = 11;
	localparam int          PD_ALL_BIT    = 12;
	localparam int          STOP_CORE_BIT = 13;
	localparam int          STOP_ALL_BIT  = 14;
	localparam int          BYP_STAT_BIT  = 15;
	localparam logic [6:0]  MULT_SELECT_RST      = 7'h03;

	// Boot entry point after a soft reset.
	localparam logic [23:0] BOOT_ADDR     = 24'hff0000;

	// Lock counter width and the count at which clocking is trusted.
	localparam int          LOCK_W        = 16;
	localparam logic [15:0] LOCK_DONE     = 16'h0200;

	// Wake latencies in cycles for each low-power mode.
	localparam int          WAKE_W        = 10;
	localparam logic [9:0]  WAKE_IDLE     = 10'h002;
	localparam logic [9:0]  WAKE_PD_CORE  = 10'h002;
	localparam logic [9:0]  WAKE_PD_CP    = 10'h006;
	localparam logic [9:0]  WAKE_PD_ALL   = 10'h1f4;

	// Power sequencing state and the kind of low-power mode chosen at idle.
	typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_WAKE} cgr_pm_t;
	typedef enum logic [1:0] {LP_IDLE, LP_PD_CORE, LP_PD_CP, LP_PD_ALL} cgr_lp_t;

endpackage

`default_nettype wire

/* File: cgr_lock_if.sv */
`default_nettype none

interface cgr_lock_if;
	logic                      restart; // Clears the counter.
	logic                      tick;    // One peripheral clock cycle elapsed.
	logic                      forced;  // A reset is active.
	logic [cgr_pkg::LOCK_W-1:0] count;  // Present counter value.
	logic                      locked;  // Lock indication.

	modport ctl (output restart, output tick, output forced, input count, input locked);
	modport ctr (input restart, input tick, input forced, output count, output locked);
endinterface

`default_nettype wire

/* File: cgr_lock_ctr.sv */
`default_nettype none

module cgr_lock_ctr (
	input  wire logic clk_sys, // System clock.
	input  wire logic srst,    // Synchronous reset, active high.
	cgr_lock_if.ctr   lk       // Lock counter link.
);

	logic [cgr_pkg::LOCK_W-1:0] cnt_q;
	logic [cgr_pkg::LOCK_W-1:0] cnt_d;
	logic                       at_done;

	// The counter starts saturated so the clock is trusted from the first cycle after hardware reset.
	assign at_done = (cnt_q == cnt_d) && (cnt_q == cgr_pkg::LOCK_DONE);
	assign cnt_d   = lk.restart ? '0 :
	                 ((lk.tick && (cnt_q != cgr_pkg::LOCK_DONE)) ? cnt_q + 16'h0001 : cnt_q);

	// Counter register.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt_q <= cgr_pkg::LOCK_DONE;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign lk.count  = cnt_q;
	assign lk.locked = lk.forced || (cnt_q == cgr_pkg::LOCK_DONE);

	AST_LOCK_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
		lk.restart |=> (lk.count == 16'h0000))
		else $error("Lock counter did not clear on restart.");

	AST_LOCK_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
		(lk.count == 16'h0200) && !lk.restart |=> (lk.count == 16'h0200) && lk.locked)
		else $error("Lock counter left its locked count.");

	AST_LOCK_FORCE: assert property (@(posedge clk_sys)
		lk.forced |-> lk.locked)
		else $error("Lock not forced during reset.");

	AST_LOCK_STEP: assert property (@(posedge clk_sys) disable iff (srst)
		lk.tick && !lk.restart && (lk.count < 16'h0200) |=> (lk.count == $past(lk.count) + 16'h0001))
		else $error("Lock counter did not step on a peripheral tick.");

	logic unused_done;
	assign unused_done = at_done;

endmodule

`default_nettype wire

/* File: cgr_top.sv */
// Operation
// - Staged configuration has no effect until soft reset.
// - Soft reset copies staged into live configuration.
// - Writing 7 to bits 2:0 starts soft reset.
// - Soft reset spares PLL and its control register.
// - Boot starts at 0xff0000 after soft reset.
// - Bypass pin sampled at reset; zero selects multiplication.
// - Feedback divide N from bits 4:0, zero means 32.
// - VCO ratio follows input halving and bit 5.
// - Bit 6 halves core clock from VCO.
// - Bypass core clock is input, optionally halved.
// - Peripheral ratio bit halves peripheral clock.
// - Clock output pin gated by its enable bit.
// - Multiplier field powers up as 0x03.
// - Multiplier writes apply at once; software awaits lock.
// - Lock indication forced active during reset.
// - Lock counter clears on PLL events, counts peripheral cycles.
// - Idle selects one of four low-power modes.
// - Plain idle keeps clocks, resumes after two cycles.
// - Power-down core stops core clock only.
// - Bypass status shows sampled pin value.
// - Power-down core wakes after two cycles.
// - Stop-all stops both clocks, wakes in six.
// - Power-down-all stops PLL, wakes after 500.
// - Core and peripheral resets are hardware OR soft.
`default_nettype none

module cgr_top (
	input  wire logic                         clk_sys,          // Input clock, also the logic clock.
	input  wire logic                         srst,             // Hardware reset, active high.
	input  wire logic                         bypass_pin,       // Bypass strap pin, asynchronous.
	input  wire logic                         next_cfg_wr,      // Write strobe for next_config_reg.
	input  wire logic [cgr_pkg::CFG_W-1:0]    next_cfg_wdata,   // Data for next_config_reg.
	input  wire logic                         soft_rst_wr,      // Write strobe for soft_reset_reg.
	input  wire logic [cgr_pkg::SWR_W-1:0]    soft_rst_wdata,   // Data for soft_reset_reg.
	input  wire logic                         pll_ctl_wr,       // Write strobe for pll_control_reg.
	input  wire logic [cgr_pkg::PLL_W-1:0]    pll_ctl_wdata,    // Data for pll_control_reg.
	input  wire logic                         idle_exec,        // Core executes idle, one-cycle pulse.
	input  wire logic                         irq_wake,         // Interrupt request, level.
	output logic      [cgr_pkg::CFG_W-1:0]    next_config_reg,  // Staged configuration.
	output logic      [cgr_pkg::CFG_W-1:0]    live_config_reg,  // Live system configuration.
	output logic      [cgr_pkg::PLL_W-1:0]    pll_control_reg,  // PLL control read value.
	output logic      [cgr_pkg::LOCK_W-1:0]   lock_count,       // Lock counter value.
	output logic                              pll_locked,       // Lock indication.
	output logic                              core_rst,         // Reset to the core.
	output logic                              periph_rst,       // Reset to the peripherals.
	output logic                              boot_start,       // Boot sequence start, pulse.
	output logic      [23:0]                  boot_addr,        // Boot entry address.
	output logic      [5:0]                   core_num,         // Core clock multiplier.
	output logic      [2:0]                   core_den,         // Core clock divisor.
	output logic      [3:0]                   periph_den,       // Peripheral clock divisor, input to peripheral.
	output logic                              core_clk,         // Core clock enable tick.
	output logic                              periph_clk,       // Peripheral clock enable tick.
	output logic                              clk_out_pin,      // Clock output pin level.
	output logic                              pll_running,      // PLL powered and running.
	output logic                              core_halted,      // Core is not executing.
	output logic                              pipe_kept,        // Pipeline contents retained.
	output logic                              core_resume       // Core resumes, one-cycle pulse.
);

	// Bypass pin synchroniser and strap capture.
	logic [2:0] byp_sync_q;
	logic       byp_stable_q;
	logic       byp_sample_q;
	logic       bypass_status;

	// Three stages; only the agreeing pair of the last two moves the filtered level.
	always_ff @(posedge clk_sys) begin
		byp_sync_q <= {byp_sync_q[1:0], bypass_pin};
	end

	// The filtered level settles one cycle after the last two stages agree.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			byp_stable_q <= 1'b1;
		end else if (byp_sync_q[1] == byp_sync_q[2]) begin
			byp_stable_q <= byp_sync_q[2];
		end
	end

	// The strap is caught after hardware reset is released, never under it.
	logic byp_pend_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			byp_pend_q <= 1'b1;
			byp_sample_q <= 1'b1;
		end else if (byp_pend_q && (byp_sync_q[1] == byp_sync_q[2])) begin
			byp_pend_q <= 1'b0;
			byp_sample_q <= byp_sync_q[2];
		end
	end
	assign bypass_status = byp_sample_q;

	// Soft reset sequencing.
	logic       swr_hit;
	logic       swr_act_q;
	logic [7:0] swr_cnt_q;
	logic       swr_done;
	assign swr_hit  = soft_rst_wr && (soft_rst_wdata[2:0] == cgr_pkg::SWR_PATTERN);
	assign swr_done = swr_act_q && (swr_cnt_q == 8'h00);

	// Holds soft reset for a fixed length; the hardware reset timer is not involved.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			swr_act_q <= 1'b0;
			swr_cnt_q <= 8'h00;
		end else if (swr_hit && !swr_act_q) begin
			swr_act_q <= 1'b1;
			swr_cnt_q <= cgr_pkg::SWR_LEN - 8'h01;
		end else if (swr_done) begin
			swr_act_q <= 1'b0;
		end else if (swr_act_q) begin
			swr_cnt_q <= swr_cnt_q - 8'h01;
		end
	end

	assign core_rst   = srst || swr_act_q;
	assign periph_rst = srst || swr_act_q;

	// Boot request follows the end of a soft reset.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			boot_start <= 1'b0;
		end else begin
			boot_start <= swr_done;
		end
	end
	assign boot_addr = cgr_pkg::BOOT_ADDR;

	// Configuration registers: staged value only reaches the live copy on soft reset.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			next_config_reg <= cgr_pkg::CFG_RST;
			live_config_reg <= cgr_pkg::CFG_RST;
		end else begin
			if (next_cfg_wr) begin
				next_config_reg <= next_cfg_wdata;
			end
			if (swr_hit && !swr_act_q) begin
				live_config_reg <= next_config_reg;
			end
		end
	end

	// PLL control register; only hardware reset touches it.
	logic [6:0] mult_select;
	logic       input_halve, bypass_halve, periph_ratio, clk_out_enable;
	logic       pll_off, power_down_all, stop_core_clk, stop_all_clks;
	logic       mult_select_change;
	assign mult_select_change = pll_ctl_wr && (pll_ctl_wdata[6:0] != mult_select);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mult_select    <= cgr_pkg::MULT_SELECT_RST;
			input_halve    <= 1'b0;
			bypass_halve   <= 1'b0;
			periph_ratio   <= 1'b0;
			clk_out_enable <= 1'b0;
			pll_off        <= 1'b0;
			power_down_all <= 1'b0;
			stop_core_clk  <= 1'b0;
			stop_all_clks  <= 1'b0;
		end else if (pll_ctl_wr) begin
			mult_select    <= pll_ctl_wdata[cgr_pkg::MULT_SELECT_LSB +: cgr_pkg::MULT_SELECT_W];
			input_halve    <= pll_ctl_wdata[cgr_pkg::HALVE_IN_BIT];
			bypass_halve   <= pll_ctl_wdata[cgr_pkg::BYP_HALVE_BIT];
			periph_ratio   <= pll_ctl_wdata[cgr_pkg::PER_RATIO_BIT];
			clk_out_enable <= pll_ctl_wdata[cgr_pkg::CLKOE_BIT];
			pll_off        <= pll_ctl_wdata[cgr_pkg::PLL_OFF_BIT];
			power_down_all <= pll_ctl_wdata[cgr_pkg::PD_ALL_BIT];
			stop_core_clk  <= pll_ctl_wdata[cgr_pkg::STOP_CORE_BIT];
			stop_all_clks  <= pll_ctl_wdata[cgr_pkg::STOP_ALL_BIT];
		end
	end

	assign pll_control_reg = {bypass_status, stop_all_clks, stop_core_clk, power_down_all, pll_off,
	                          clk_out_enable, periph_ratio, bypass_halve, input_halve, mult_select};

	// Feedback divide N, where a zero field stands for the largest ratio.
	function automatic logic [5:0] fb_n(input logic [4:0] f);
		fb_n = (f == 5'h00) ? 6'h20 : {1'b0, f};
	endfunction

	// Ratio of core clock to input clock as multiplier over divisor.
	logic [5:0] num_w;
	logic [2:0] den_w;
	logic [3:0] pden_w;
	logic [1:0] vco_den;
	assign vco_den = (input_halve && !mult_select[5]) ? 2'h2 : 2'h1;
	assign num_w   = bypass_status ? 6'h01 : fb_n(mult_select[4:0]);
	assign den_w   = bypass_status ? (bypass_halve ? 3'h2 : 3'h1) :
	                 (mult_select[6] ? {vco_den, 1'b0} : {1'b0, vco_den});
	assign pden_w  = periph_ratio ? {den_w, 1'b0} : {1'b0, den_w};

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			core_num   <= 6'h01;
			core_den   <= 3'h1;
			periph_den <= 4'h1;
		end else begin
			core_num   <= num_w;
			core_den   <= den_w;
			periph_den <= pden_w;
		end
	end

	// Power sequencing: choose a mode at idle and count the wake latency.
	cgr_pkg::cgr_pm_t pm_q;
	cgr_pkg::cgr_lp_t lp_q;
	cgr_pkg::cgr_lp_t lp_sel;
	logic [cgr_pkg::WAKE_W-1:0] wake_q;
	logic [cgr_pkg::WAKE_W-1:0] wake_len;
	assign lp_sel = power_down_all ? cgr_pkg::LP_PD_ALL :
	                stop_all_clks  ? cgr_pkg::LP_PD_CP  :
	                stop_core_clk  ? cgr_pkg::LP_PD_CORE : cgr_pkg::LP_IDLE;
	assign wake_len = (lp_q == cgr_pkg::LP_PD_ALL) ? cgr_pkg::WAKE_PD_ALL :
	                  (lp_q == cgr_pkg::LP_PD_CP)  ? cgr_pkg::WAKE_PD_CP  :
	                  (lp_q == cgr_pkg::LP_PD_CORE) ? cgr_pkg::WAKE_PD_CORE : cgr_pkg::WAKE_IDLE;

	always_ff @(posedge clk_sys) begin
		if (core_rst) begin
			pm_q   <= cgr_pkg::PM_RUN;
			lp_q   <= cgr_pkg::LP_IDLE;
			wake_q <= '0;
		end else begin
			case (pm_q)
				cgr_pkg::PM_RUN: begin
					if (idle_exec) begin
						pm_q <= cgr_pkg::PM_SLEEP;
						lp_q <= lp_sel;
					end
				end
				cgr_pkg::PM_SLEEP: begin
					if (irq_wake) begin
						pm_q   <= cgr_pkg::PM_WAKE;
						wake_q <= wake_len - 10'h001;
					end
				end
				cgr_pkg::PM_WAKE: begin
					if (wake_q == '0) begin
						pm_q <= cgr_pkg::PM_RUN;
					end else begin
						wake_q <= wake_q - 10'h001;
					end
				end
				default: begin
					pm_q <= cgr_pkg::PM_RUN;
				end
			endcase
		end
	end

	logic asleep;
	logic core_run, periph_run;
	assign asleep      = (pm_q != cgr_pkg::PM_RUN);
	assign core_resume = (pm_q == cgr_pkg::PM_WAKE) && (wake_q == '0);
	assign core_halted = asleep;
	assign core_run    = !asleep || (lp_q == cgr_pkg::LP_IDLE);
	assign periph_run  = !asleep || (lp_q == cgr_pkg::LP_IDLE) || (lp_q == cgr_pkg::LP_PD_CORE);
	assign pipe_kept   = (lp_q == cgr_pkg::LP_IDLE) || (lp_q == cgr_pkg::LP_PD_CORE);
	// The PLL restarts at the beginning of the power-down-all wake so it can settle.
	assign pll_running = !pll_off && !((pm_q == cgr_pkg::PM_SLEEP) && (lp_q == cgr_pkg::LP_PD_ALL));

	// Clock ticks. In multiplication mode the PLL output cannot be shown, so a tick each cycle stands in.
	logic [1:0] div_q;
	logic       core_base, per_base;
	assign core_base = !bypass_status || (!core_den[1] || div_q[0] == 1'b0);
	assign per_base  = !bypass_status || ((div_q & {pden_w[2], pden_w[2] | pden_w[1]}) == 2'h0);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end

	assign core_clk   = core_base && core_run && pll_running;
	assign periph_clk = per_base && periph_run && pll_running;

	// Output pin toggles on peripheral ticks; internal clocks ignore the enable.
	always_ff @(posedge clk_sys) begin
		if (srst || !clk_out_enable) begin
			clk_out_pin <= 1'b0;
		end else if (periph_clk) begin
			clk_out_pin <= !clk_out_pin;
		end
	end

	// Lock counter restarts when the PLL turns on, on deep wake, or on a new multiplier.
	cgr_lock_if lk ();
	logic pll_off_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pll_off_q <= 1'b0;
		end else begin
			pll_off_q <= pll_off;
		end
	end
	assign lk.restart = (pll_off_q && !pll_off) || mult_select_change ||
	                    (irq_wake && (pm_q == cgr_pkg::PM_SLEEP) && (lp_q == cgr_pkg::LP_PD_ALL));
	assign lk.tick    = per_base && pll_running;
	assign lk.forced  = core_rst;

	cgr_lock_ctr u_lock (
		.clk_sys (clk_sys),
		.srst    (srst),
		.lk      (lk)
	);
	assign lock_count = lk.count;
	assign pll_locked = lk.locked;

	AST_SWR_LIVE: assert property (@(posedge clk_sys) disable iff (srst)
		swr_hit && !swr_act_q |=> (live_config_reg == $past(next_config_reg)) && core_rst)
		else $error("Live configuration not loaded on soft reset.");

	AST_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (srst)
		!(swr_hit && !swr_act_q) |=> $stable(live_config_reg))
		else $error("Live configuration changed without soft reset.");

	AST_SWR_PLL: assert property (@(posedge clk_sys) disable iff (srst)
		swr_act_q && !pll_ctl_wr |=> $stable(pll_control_reg[14:0]))
		else $error("PLL control changed by soft reset.");

	AST_BOOT: assert property (@(posedge clk_sys) disable iff (srst)
		swr_hit && !swr_act_q |-> ##5 boot_start && (boot_addr == 24'hff0000))
		else $error("Boot did not follow soft reset.");

	AST_WAKE_IDLE: assert property (@(posedge clk_sys) disable iff (core_rst)
		(pm_q == cgr_pkg::PM_SLEEP) && (lp_q == cgr_pkg::LP_IDLE) && irq_wake |-> !core_resume ##2 core_resume)
		else $error("Idle wake latency wrong.");

	AST_WAKE_CP: assert property (@(posedge clk_sys) disable iff (core_rst)
		(pm_q == cgr_pkg::PM_SLEEP) && (lp_q == cgr_pkg::LP_PD_CP) && irq_wake |-> !core_resume[*6] ##1 core_resume)
		else $error("Stop-all wake latency wrong.");

	AST_WAKE_ALL: assert property (@(posedge clk_sys) disable iff (core_rst)
		(pm_q == cgr_pkg::PM_SLEEP) && (lp_q == cgr_pkg::LP_PD_ALL) && irq_wake |-> ##[500:500] core_resume)
		else $error("Power-down-all wake latency wrong.");

	AST_PD_CORE: assert property (@(posedge clk_sys) disable iff (core_rst)
		(pm_q == cgr_pkg::PM_SLEEP) && (lp_q == cgr_pkg::LP_PD_CORE) |-> !core_clk && pll_running == !pll_off)
		else $error("Power-down-core clocks wrong.");

	AST_RATIO: assert property (@(posedge clk_sys) disable iff (srst)
		!bypass_status && (mult_select == 7'h40) && !input_halve |=> (core_num == 6'h20) && (core_den == 3'h2))
		else $error("Multiplier decode wrong.");

endmodule

`default_nettype wire

/* File: cgr_tb.sv */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        bypass_pin = 1'b1;
	logic        next_cfg_wr = 1'b0;
	logic        soft_rst_wr = 1'b0;
	logic        pll_ctl_wr = 1'b0;
	logic        idle_exec = 1'b0;
	logic        irq_wake = 1'b0;
	logic [15:0] next_cfg_wdata = 16'h0000;
	logic [15:0] soft_rst_wdata = 16'h0000;
	logic [15:0] pll_ctl_wdata = 16'h0000;
	logic [15:0] next_config_reg, live_config_reg, pll_control_reg, lock_count;
	logic        pll_locked, core_rst, periph_rst, boot_start;
	logic [23:0] boot_addr;
	logic [5:0]  core_num;
	logic [2:0]  core_den;
	logic [3:0]  periph_den;
	logic        core_clk, periph_clk, clk_out_pin, pll_running, core_halted, pipe_kept, core_resume;
	int          bad_count = 0;
	int          compares = 0;
	logic [31:0] rs = 32'hcb78d572;

	cgr_top i_cgr_top (.clk_sys, .srst, .bypass_pin, .next_cfg_wr, .next_cfg_wdata, .soft_rst_wr,
		.soft_rst_wdata, .pll_ctl_wr, .pll_ctl_wdata, .idle_exec, .irq_wake, .next_config_reg,
		.live_config_reg, .pll_control_reg, .lock_count, .pll_locked, .core_rst, .periph_rst,
		.boot_start, .boot_addr, .core_num, .core_den, .periph_den, .core_clk, .periph_clk,
		.clk_out_pin, .pll_running, .core_halted, .pipe_kept, .core_resume);

	// An 8 ns period gives the 125 MHz system clock.
	always #4 clk_sys = ~clk_sys;

	// Repeatable pseudo-random source, so any failure can be replayed.
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Checks land 1 ns after the edge so that the design's updates have settled.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// One write strobe: 0 staged config, 1 soft reset, 2 PLL control.
	task automatic wr(input int k, input logic [15:0] d);
		@(posedge clk_sys);
		next_cfg_wr <= (k == 0);
		soft_rst_wr <= (k == 1);
		pll_ctl_wr <= (k == 2);
		next_cfg_wdata <= d;
		soft_rst_wdata <= d;
		pll_ctl_wdata <= d;
		@(posedge clk_sys);
		next_cfg_wr <= 1'b0;
		soft_rst_wr <= 1'b0;
		pll_ctl_wr <= 1'b0;
		#1;
	endtask

	// Ratios are compared by cross-multiplying, since num/den need not be reduced.
	task automatic chk_ratio(input logic [15:0] c, input logic byp);
		logic [5:0] n;
		logic [3:0] d;
		n = byp ? 6'h01 : (c[4:0] == 5'h00 ? 6'h20 : {1'b0, c[4:0]});
		d = byp ? 4'h1 << c[8] : 4'h1 << ({1'b0, c[6]} + {1'b0, c[7] & ~c[5]});
		chk("core ratio", core_num * d, n * core_den);
		chk("periph ratio", core_num * (d << c[9]), n * periph_den);
	endtask

	task automatic do_reset(input logic byp);
		@(posedge clk_sys);
		srst <= 1'b1;
		bypass_pin <= byp;
		cyc(4);
		chk("locked in reset", pll_locked, 1);
		chk("resets in reset", {core_rst, periph_rst}, 2'h3);
		@(posedge clk_sys);
		srst <= 1'b0;
		cyc(6);
		chk("mult field", pll_control_reg[6:0], 7'h03);
		chk("bypass status", pll_control_reg[15], byp);
		chk("resets off", {core_rst, periph_rst}, 2'h0);
		chk("lock count", lock_count, 16'h0200);
		chk_ratio(16'h0003, byp);
	endtask

	// Bypass then multiplication mode, lock, clock pin, staged config and soft reset, low power.
	initial begin
		logic [15:0] c;
		logic [15:0] nx;
		logic        b;
		int          n;
		int          nc;
		int          lat[4] = '{2, 2, 6, 500};
		logic [15:0] md[4] = '{16'h0000, 16'h2000, 16'h4000, 16'h1000};
		logic [3:0]  ck[4] = '{4'hf, 4'he, 4'h4, 4'h0};
		c = 16'h0003;
		for (int m = 1; m >= 0; m--) begin
			do_reset(m[0]);
			for (int i = 0; i < 6; i++) begin
				c = 16'(xs()) & 16'h03ff;
				if (c[5]) c[7] = 1'b1;
				wr(2, c);
				cyc(1);
				chk("ctl readback", pll_control_reg[14:0], c[14:0]);
				chk_ratio(c, m[0]);
				// Four cycles see every phase of the divider, so the tick counts are exact.
				n = 0;
				nc = 0;
				for (int j = 0; j < 4; j++) begin
					n += periph_clk;
					nc += core_clk;
					cyc(1);
				end
				chk("periph ticks", n, m[0] ? 4 >> ({1'b0, c[8]} + {1'b0, c[9]}) : 4);
				chk("core ticks", nc, m[0] ? 4 >> c[8] : 4);
			end
		end
		wr(2, 16'h0001);
		wr(2, 16'h0003);
		chk("lock restart", {pll_locked, lock_count}, 17'h00000);
		cyc(511);
		chk("lock counting", {pll_locked, lock_count}, 17'h001ff);
		cyc(1);
		chk("lock reached", {pll_locked, lock_count}, 17'h10200);
		cyc(3);
		chk("lock held", {pll_locked, lock_count}, 17'h10200);
		for (n = 0; n < 8; n++) begin
			b = clk_out_pin;
			cyc(1);
			if (n < 4) chk("clk out off", clk_out_pin, 0);
			else chk("clk out toggle", clk_out_pin, !b);
			if (n == 3) wr(2, 16'h0403);
		end
		nx = 16'(xs());
		wr(0, nx);
		chk("next cfg", next_config_reg, nx);
		chk("live cfg held", live_config_reg, 16'h0000);
		wr(1, 16'hfff6);
		chk("wrong pattern", core_rst, 0);
		wr(1, 16'h0007);
		chk("live cfg", live_config_reg, nx);
		for (n = 0; n < 4; n++) begin
			chk("soft resets", {core_rst, periph_rst}, 2'h3);
			cyc(1);
		end
		chk("boot start", {core_rst, boot_start}, 2'h1);
		chk("boot addr", boot_addr, 24'hff0000);
		chk("pll kept", {pll_locked, pll_control_reg[14:0]}, 16'h8403);
		cyc(1);
		chk("boot pulse", boot_start, 0);
		for (int k = 0; k < 4; k++) begin
			wr(2, 16'h0003 | md[k]);
			@(posedge clk_sys);
			idle_exec <= 1'b1;
			@(posedge clk_sys);
			idle_exec <= 1'b0;
			#1;
			chk("halted", core_halted, 1);
			chk("sleep clocks", {pipe_kept, pll_running, periph_clk, core_clk}, ck[k]);
			@(posedge clk_sys);
			irq_wake <= 1'b1;
			n = 0;
			do begin
				cyc(1);
				n++;
			end while (core_resume !== 1'b1 && n < 600);
			chk("wake latency", n, lat[k]);
			if (n >= 600) finish_test();
			@(posedge clk_sys);
			irq_wake <= 1'b0;
			cyc(3);
			chk("running again", core_halted, 0);
		end
		finish_test();
	end
endmodule

`default_nettype wire
